// >>> hdl/adc_cfg_pkg.sv
// Constants, field layout and state types for the converter
// configuration register and serial readout port.
// Assumes a single system clock; no surrounding bus.
//
// Overview of operation
// RL1 - Range field picks integrator capacitor: 00 3 pC, 01 6 pC, else largest.
// RL2 - Bits 9, 5 and 3..0 are unused, cleared at reset, written zero.
// RL3 - Speed select 0 means high speed, 1 normal speed and reset default.
// RL4 - High speed results carry only 12-bit level performance.
// RL5 - Test code 00 is normal; 01 opens all sixteen inputs.
// RL6 - Test code 10 opens inputs and adds a 10 pF capacitor.
// RL7 - Test code 11 opens inputs, injects about 1.5 pC per toggle.
// RL8 - Reference buffer off bit: 0 enables buffer, 1 disables, default off.
// RL9 - Host finishes configuration access entirely before or after a toggle.
// RL10 - Serial configuration input sampled on every falling system clock edge.
// RL11 - Four preamble bits must equal 1010 before the next 16 load.
// RL12 - Receive shift register clears right after a load.
// RL13 - Host keeps the configuration input low when idle.
// RL14 - New configuration is copied into the output shifter for readback.
// RL15 - Unread configuration is replaced by data of the next conversion.
// RL16 - Serial output data change on each falling readout clock edge.
// RL17 - Host holds the readout clock low when idle; never free-running.
// RL18 - Ready strobe falls on a system clock edge, rises at first readout fall.
// RL19 - Host may poll the strobe or count clocks after a toggle.
// RL20 - Daisy chaining works only in time-multiplexed output mode.
// RL21 - Host gives extra readout clocks to pass chained data through.
// RL22 - Host ties the chain input low when chaining is unused.
// RL23 - Output mode 0 gives four parallel lanes, 1 multiplexes onto primary.
// RL24 - Width field: 00 16 bits, 01 14 bits, else 12 bits.
// RL25 - Bit 15 resets to zero and the host programs it to one.
// RL26 - Every word leaves most significant bit first.
// RL27 - In daisy chain mode, chain input bits follow the own words.
package adc_cfg_pkg;
  // Register layout
  localparam int CFG_W = 16;
  localparam int KEEP1_BIT = 15;
  localparam int MODE_BIT = 14;
  localparam int WSEL_LSB = 12;
  localparam int RANGE_LSB = 10;
  localparam int SPEED_BIT = 8;
  localparam int TEST_LSB = 6;
  localparam int REFOFF_BIT = 4;
  localparam logic [15:0] CFG_RESET = 16'h0110;
  // Configuration frame
  localparam logic [3:0] PREAMBLE = 4'ha;
  localparam int PREAMBLE_W = 4;
  localparam int FRAME_BITS = PREAMBLE_W + CFG_W;
  localparam logic [4:0] RX_CNT_LAST = 5'h13;
  // Output word widths
  localparam logic [1:0] WSEL_16 = 2'h0;
  localparam logic [1:0] WSEL_14 = 2'h1;
  localparam logic [4:0] BITS_16 = 5'h10;
  localparam logic [4:0] BITS_14 = 5'he;
  localparam logic [4:0] BITS_12 = 5'hc;
  // Range and test codes
  localparam logic [1:0] RANGE_3PC = 2'h0;
  localparam logic [1:0] RANGE_6PC = 2'h1;
  localparam logic [1:0] TEST_NORMAL = 2'h0;
  localparam logic [1:0] TEST_CAP = 2'h2;
  localparam logic [1:0] TEST_CHARGE = 2'h3;
  typedef enum logic [1:0] {CAP_3PC = 2'h0, CAP_6PC = 2'h1, CAP_LARGEST = 2'h3} cap_sel_t;
  typedef enum logic [0:0] {RX_IDLE = 1'h0, RX_SHIFT = 1'h1} rx_state_t;
  typedef enum logic [1:0] {LD_IDLE = 2'h0, LD_CFG = 2'h1, LD_INTEGRATOR_SIDE_TOGGLE = 2'h3} ld_state_t;
endpackage : adc_cfg_pkg

// >>> hdl/stream_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and flush.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("stream_fifo: DEPTH must be a power of two");
  end

  // Occupancy flags and handshakes; flush wins over both sides
  assign in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  assign push = in_valid_i && in_ready_o && !flush_i;
  assign pop = out_valid_o && out_ready_i && !flush_i;

  // Pointers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  // Storage
  always_ff @(posedge clk_i) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data_i;
  end
endmodule : stream_fifo
`default_nettype wire

// >>> hdl/adc_config_readout.sv
// Configuration register, serial configuration receiver and
// serial result readout of a sixteen channel converter.
// Assumes the configuration input is synchronous to clk_i; the
// readout clock, toggle and chain input are asynchronous pins.
`timescale 1ns/10ps
`default_nettype none
module adc_config_readout #(
  parameter int WORD_W = 16,
  parameter int LANES = 4,
  parameter int CHANNELS = 16,
  parameter int FIFO_DEPTH = 4
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Host pins
  input wire logic cfg_serial_i,
  input wire logic readout_clock_i,
  input wire logic integrator_side_toggle_i,
  input wire logic chain_serial_i,
  output logic primary_serial_out_o,
  output logic [LANES-2:0] aux_serial_out_o,
  output logic data_ready_n_o,
  // Conversion results
  input wire logic integrator_side_toggle_done_i,
  input wire logic [CHANNELS*WORD_W-1:0] integrator_side_toggle_words_i,
  // Front-end controls
  output var adc_cfg_pkg::cap_sel_t integ_cap_sel_o,
  output logic normal_speed_o,
  output logic reduced_12bit_o,
  output logic inputs_open_o,
  output logic test_cap_on_o,
  output logic charge_inject_o,
  output logic ref_buffer_en_o,
  output logic [adc_cfg_pkg::CFG_W-1:0] cfg_word_o
);
  import adc_cfg_pkg::*;

  localparam int SH_W = LANES * WORD_W;
  localparam int ENT_W = SH_W + 1;
  localparam int GROUPS = CHANNELS / LANES;
  localparam int GRP_W = $clog2(GROUPS);
  localparam logic [GRP_W-1:0] GRP_LAST = GRP_W'(GROUPS - 1);
  localparam int NPIN = 3;

  if (WORD_W != CFG_W || LANES < 2 || CHANNELS % LANES != 0 || GROUPS < 2 ||
      (1 << GRP_W) != GROUPS || SH_W > 127) begin : g_bad_param
    $error("adc_config_readout: unsupported lane or channel geometry");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Output word width from the width field
  function automatic logic [4:0] word_bits(input logic [1:0] wsel);
    case (wsel)
      WSEL_16: word_bits = BITS_16;
      WSEL_14: word_bits = BITS_14;
      default: word_bits = BITS_12;
    endcase
  endfunction : word_bits

  // Concatenate the top w bits of each lane, lane 0 first
  function automatic logic [SH_W-1:0] pack_tdm(input logic [SH_W-1:0] lanes, input int w);
    logic [SH_W-1:0] r;
    int pos;
    r = '0;
    pos = SH_W - 1;
    for (int j = LANES - 1; j >= 0; j--) begin
      for (int b = WORD_W - 1; b >= 0; b--) begin
        if (b >= WORD_W - w) begin
          r[pos] = lanes[j*WORD_W+b];
          pos--;
        end
      end
    end
    return r;
  endfunction : pack_tdm

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [NPIN-1:0] pin_raw;
  logic [2:0] pin_sync_q [NPIN];
  logic [NPIN-1:0] pin_lvl_q;
  logic [NPIN-1:0] pin_edge;
  logic [NPIN-1:0] pin_fall;
  logic rd_fall;
  logic tgl_edge;
  logic chain_lvl;

  // Two-stage reset release
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign pin_raw = {chain_serial_i, integrator_side_toggle_i, readout_clock_i};

  // Three flops; a change counts once stages two and three agree
  for (genvar k = 0; k < NPIN; k++) begin : g_pin
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        pin_sync_q[k] <= 3'h0;
        pin_lvl_q[k] <= 1'b0;
      end else begin
        pin_sync_q[k] <= {pin_sync_q[k][1:0], pin_raw[k]};
        if (pin_sync_q[k][1] == pin_sync_q[k][2]) pin_lvl_q[k] <= pin_sync_q[k][2];
      end
    end
    assign pin_edge[k] = (pin_sync_q[k][1] == pin_sync_q[k][2]) &&
                         (pin_sync_q[k][2] != pin_lvl_q[k]);
    assign pin_fall[k] = pin_edge[k] && !pin_sync_q[k][2];
  end

  assign rd_fall = pin_fall[0];
  assign tgl_edge = pin_edge[1];
  assign chain_lvl = pin_lvl_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration receiver on the falling system clock edge

  rx_state_t rx_state_q;
  logic [FRAME_BITS-1:0] rx_sr_q;
  logic [4:0] rx_cnt_q;
  logic [FRAME_BITS-1:0] rx_frame;
  logic [CFG_W-1:0] cfg_rx_q;
  logic cfg_load_q;
  logic [CFG_W-1:0] cfg_q;

  assign rx_frame = {rx_sr_q[FRAME_BITS-2:0], cfg_serial_i};

  // Frame starts on the first one after an idle-low line [RL13]
  always_ff @(negedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_q <= RX_IDLE;
      rx_sr_q <= '0;
      rx_cnt_q <= 5'h0;
      cfg_rx_q <= CFG_RESET;
      cfg_load_q <= 1'b0;
    end else begin
      cfg_load_q <= 1'b0;
      case (rx_state_q)
        RX_IDLE: begin
          if (cfg_serial_i) begin // [RL10]
            rx_sr_q <= rx_frame;
            rx_cnt_q <= 5'h1;
            rx_state_q <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (rx_cnt_q == RX_CNT_LAST) begin
            cfg_load_q <= rx_frame[FRAME_BITS-1 -: PREAMBLE_W] == PREAMBLE; // [RL11]
            cfg_rx_q <= rx_frame[CFG_W-1:0];
            rx_sr_q <= '0; // [RL12]
            rx_cnt_q <= 5'h0;
            rx_state_q <= RX_IDLE;
          end else begin
            rx_sr_q <= rx_frame; // [RL10]
            rx_cnt_q <= rx_cnt_q + 5'h1;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // Configuration register; reset clears unused bits and bit 15
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET; // [RL2] [RL3] [RL8] [RL25]
    end else if (cfg_load_q) begin
      cfg_q <= cfg_rx_q; // [RL11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Front-end control decode

  logic tdm;
  logic [1:0] test_sel;
  logic [4:0] wbits;
  cap_sel_t cap_d;

  assign tdm = cfg_q[MODE_BIT]; // [RL23]
  assign test_sel = cfg_q[TEST_LSB +: 2];
  assign wbits = word_bits(cfg_q[WSEL_LSB +: 2]); // [RL24]
  assign cap_d = (cfg_q[RANGE_LSB +: 2] == RANGE_3PC) ? CAP_3PC :
                 (cfg_q[RANGE_LSB +: 2] == RANGE_6PC) ? CAP_6PC : CAP_LARGEST; // [RL1]

  // Registered controls to the analog side
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      integ_cap_sel_o <= CAP_3PC;
      normal_speed_o <= 1'b1;
      reduced_12bit_o <= 1'b0;
      inputs_open_o <= 1'b0;
      test_cap_on_o <= 1'b0;
      charge_inject_o <= 1'b0;
      ref_buffer_en_o <= 1'b0;
      cfg_word_o <= CFG_RESET;
    end else begin
      integ_cap_sel_o <= cap_d; // [RL1]
      normal_speed_o <= cfg_q[SPEED_BIT]; // [RL3]
      reduced_12bit_o <= !cfg_q[SPEED_BIT]; // [RL4]
      inputs_open_o <= test_sel != TEST_NORMAL; // [RL5]
      test_cap_on_o <= test_sel == TEST_CAP; // [RL6]
      charge_inject_o <= tgl_edge && (test_sel == TEST_CHARGE); // [RL7]
      ref_buffer_en_o <= !cfg_q[REFOFF_BIT]; // [RL8]
      cfg_word_o <= cfg_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result capture and FIFO loader

  logic [WORD_W-1:0] integrator_side_toggle_mem_q [CHANNELS];
  ld_state_t ld_state_q;
  logic [GRP_W-1:0] grp_q;
  logic start;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [ENT_W-1:0] fifo_out_data;
  logic [SH_W-1:0] grp_lanes;
  logic [ENT_W-1:0] ld_data;
  logic push_ok;
  logic pop;

  // A new configuration or conversion discards unread output
  assign start = cfg_load_q || integrator_side_toggle_done_i; // [RL15]
  assign push_ok = (ld_state_q != LD_IDLE) && fifo_in_ready;

  for (genvar j = 0; j < LANES; j++) begin : g_lane
    assign grp_lanes[(LANES-1-j)*WORD_W +: WORD_W] = integrator_side_toggle_mem_q[int'(grp_q)*LANES + j];
  end
  assign ld_data = (ld_state_q == LD_CFG) ? {1'b1, cfg_q, {(SH_W-CFG_W){1'b0}}} :
                                             {1'b0, grp_lanes};

  // Results captured when the converters finish
  always_ff @(posedge clk_i) begin
    if (integrator_side_toggle_done_i) begin
      for (int c = 0; c < CHANNELS; c++) begin
        integrator_side_toggle_mem_q[c] <= integrator_side_toggle_words_i[c*WORD_W +: WORD_W];
      end
    end
  end

  // Loader; configuration readback wins over conversion
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ld_state_q <= LD_IDLE;
      grp_q <= '0;
    end else if (cfg_load_q) begin
      ld_state_q <= LD_CFG; // [RL14]
      grp_q <= '0;
    end else if (integrator_side_toggle_done_i) begin
      ld_state_q <= LD_INTEGRATOR_SIDE_TOGGLE; // [RL15]
      grp_q <= '0;
    end else if (push_ok) begin
      if (ld_state_q == LD_INTEGRATOR_SIDE_TOGGLE && grp_q != GRP_LAST) begin
        grp_q <= grp_q + 1'b1;
      end else begin
        ld_state_q <= LD_IDLE;
      end
    end
  end

  stream_fifo #(
    .WIDTH(ENT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .flush_i(start),
    .in_valid_i(ld_state_q != LD_IDLE),
    .in_ready_o(fifo_in_ready),
    .in_data_i(ld_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output shifter

  logic [SH_W-1:0] shift_q;
  logic [6:0] bits_q;
  logic batch_q;
  logic ent_cfg;
  logic [SH_W-1:0] load_val;
  logic [6:0] load_bits;
  logic [SH_W-1:0] par_shift;
  logic [LANES-2:0] aux_msb;
  logic daisy;

  assign pop = fifo_out_valid && (bits_q == 7'h0) && !start;
  assign ent_cfg = fifo_out_data[ENT_W-1];
  assign load_val = !tdm ? fifo_out_data[SH_W-1:0] :
                    pack_tdm(fifo_out_data[SH_W-1:0], ent_cfg ? CFG_W : int'(wbits));
  assign load_bits = ent_cfg ? 7'(CFG_W) : tdm ? 7'(LANES * int'(wbits)) : 7'(wbits);
  assign daisy = tdm && (ld_state_q == LD_IDLE); // [RL20] [RL22]

  // Each lane shifts on its own; lane 0 is the top segment
  for (genvar k = 0; k < LANES; k++) begin : g_seg
    assign par_shift[k*WORD_W +: WORD_W] = {shift_q[k*WORD_W +: WORD_W-1], 1'b0};
    if (k < LANES - 1) begin : g_aux
      assign aux_msb[LANES-2-k] = shift_q[k*WORD_W+WORD_W-1];
    end
  end

  // Bits leave at each readout clock fall, MSB first
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= '0;
      bits_q <= 7'h0;
      primary_serial_out_o <= 1'b0;
      aux_serial_out_o <= '0;
    end else if (start) begin
      shift_q <= '0;
      bits_q <= 7'h0;
    end else if (pop) begin
      shift_q <= load_val; // [RL24] [RL26]
      bits_q <= load_bits;
    end else if (rd_fall) begin
      if (bits_q != 7'h0) begin
        shift_q <= tdm ? {shift_q[SH_W-2:0], 1'b0} : par_shift; // [RL26]
        bits_q <= bits_q - 7'h1;
        primary_serial_out_o <= shift_q[SH_W-1]; // [RL16]
        aux_serial_out_o <= tdm ? '0 : aux_msb; // [RL23]
      end else begin
        primary_serial_out_o <= daisy ? chain_lvl : 1'b0; // [RL27] [RL21]
        aux_serial_out_o <= '0;
      end
    end
  end

  // Ready strobe: low when a batch is loaded, high at first fall
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      batch_q <= 1'b0;
      data_ready_n_o <= 1'b1;
    end else begin
      if (start) begin
        batch_q <= 1'b1;
      end else if (pop) begin
        batch_q <= 1'b0;
      end
      if (pop && batch_q) begin
        data_ready_n_o <= 1'b0; // [RL18]
      end else if (rd_fall) begin
        data_ready_n_o <= 1'b1; // [RL18]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_cfg_quiet;
    cfg_load_q ##1 (!start)[*3];
  endsequence

  AST_CAP_DECODE: assert property (@(posedge clk_i) disable iff (!rst_n) // [RL1]
    cfg_q[RANGE_LSB +: 2] == RANGE_6PC |=> integ_cap_sel_o == CAP_6PC)
    else $error("capacitor select does not follow range field");
  AST_RESET_DEFAULT: assert property (@(posedge clk_i) disable iff (!rst_n) // [RL2]
    $rose(rst_n) |-> cfg_q == CFG_RESET && normal_speed_o && !ref_buffer_en_o)
    else $error("configuration not at reset value");
  AST_SPEED: assert property (@(posedge clk_i) disable iff (!rst_n) // [RL4]
    !cfg_q[SPEED_BIT] ##1 !cfg_q[SPEED_BIT] |-> reduced_12bit_o && !normal_speed_o)
    else $error("speed select decode wrong");
  AST_TEST_OPEN: assert property (@(posedge clk_i) disable iff (!rst_n) // [RL5]
    test_sel != TEST_NORMAL |=> inputs_open_o && (test_cap_on_o == ($past(test_sel) == TEST_CAP)))
    else $error("test select decode wrong");
  AST_INJECT: assert property (@(posedge clk_i) disable iff (!rst_n) // [RL7]
    charge_inject_o |-> $past(tgl_edge) && $past(test_sel) == TEST_CHARGE)
    else $error("charge injected without toggle in test code 11");
  AST_PREAMBLE: assert property (@(negedge clk_i) disable iff (!rst_n) // [RL11]
    cfg_load_q |-> $past(rx_sr_q[FRAME_BITS-2 -: PREAMBLE_W]) == PREAMBLE &&
                   rx_sr_q == '0 && rx_state_q == RX_IDLE)
    else $error("load without valid preamble or without clearing");
  AST_CFG_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n) // [RL11]
    cfg_load_q |=> cfg_q == $past(cfg_rx_q))
    else $error("configuration register not loaded");
  AST_READBACK: assert property (@(posedge clk_i) disable iff (!rst_n) // [RL14]
    s_cfg_quiet |-> !data_ready_n_o && bits_q == 7'(CFG_W))
    else $error("configuration not offered for readback");
  AST_OVERWRITE: assert property (@(posedge clk_i) disable iff (!rst_n) // [RL15]
    integrator_side_toggle_done_i && !cfg_load_q |=> bits_q == 7'h0 && ld_state_q == LD_INTEGRATOR_SIDE_TOGGLE)
    else $error("conversion did not replace unread output");
  AST_SHIFT: assert property (@(posedge clk_i) disable iff (!rst_n) // [RL16]
    rd_fall && !start && bits_q != 7'h0 |=>
      primary_serial_out_o == $past(shift_q[SH_W-1]) && bits_q == $past(bits_q) - 7'h1)
    else $error("serial output did not shift on readout fall");
  AST_READY_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n) // [RL18]
    !data_ready_n_o && rd_fall && !pop |=> data_ready_n_o)
    else $error("ready strobe stayed low after readout fall");
  AST_DAISY: assert property (@(posedge clk_i) disable iff (!rst_n) // [RL27]
    rd_fall && !start && !pop && bits_q == 7'h0 && daisy |=>
      primary_serial_out_o == $past(chain_lvl) && aux_serial_out_o == '0)
    else $error("chain input not passed through");
endmodule : adc_config_readout
`default_nettype wire

// >>> verif/host_model.sv
// Host partner: configuration stream, readout clock, toggle and chain pins.
// Assumes the device samples its pins on clk_i; drives land at rising edges.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk_i,
  // Pins towards the device
  output logic cfg_serial_o,
  output logic readout_clock_o,
  output logic toggle_o,
  output logic chain_o,
  input wire logic primary_i
);
  // Idle levels: config low, readout clock parked low, chain low
  initial begin
    cfg_serial_o = 1'b0;
    readout_clock_o = 1'b0;
    toggle_o = 1'b0;
    chain_o = 1'b0;
  end
  // One frame, preamble then word, MSB first; caller idles the line
  task automatic send_cfg(input logic [3:0] pre, input logic [15:0] word);
    logic [19:0] bits;
    bits = {pre, word};
    for (int i = 19; i >= 0; i--) begin
      @(posedge clk_i);
      cfg_serial_o <= bits[i];
    end
  endtask : send_cfg
  // Return the configuration line to its quiet level
  task automatic idle_cfg();
    @(posedge clk_i);
    cfg_serial_o <= 1'b0;
  endtask : idle_cfg
  // One 200 ns readout pulse, 2 clk high and 6 low, bit sampled late
  task automatic read_bit(output logic b);
    @(posedge clk_i);
    readout_clock_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    readout_clock_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    b = primary_i;
  endtask : read_bit
  // Conversion toggle, only between configuration frames
  task automatic flip_toggle();
    @(posedge clk_i);
    toggle_o <= ~toggle_o;
  endtask : flip_toggle
  // Chain input level, low whenever chaining is unused
  task automatic set_chain(input logic v);
    @(posedge clk_i);
    chain_o <= v;
  endtask : set_chain
endmodule : host_model
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the converter configuration and readout port.
// Assumes the host partner model drives every pin on rising clock edges.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import adc_cfg_pkg::*;
  // Bench signals
  logic clk, reset_n, integrator_side_toggle_done, b;
  logic [255:0] integrator_side_toggle_words;
  logic [15:0] w;
  wire logic cfg_serial, rclk, toggle, chain, primary, ready_n;
  wire logic [2:0] aux;
  cap_sel_t cap_sel;
  logic normal_speed, reduced, inputs_open, test_cap, inject, buf_en;
  logic [15:0] cfg_word;
  int fails, checked;
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  adc_config_readout i_adc_config_readout (
    .clk_i(clk), .reset_n_i(reset_n), .cfg_serial_i(cfg_serial), .readout_clock_i(rclk),
    .integrator_side_toggle_i(toggle), .chain_serial_i(chain), .primary_serial_out_o(primary),
    .aux_serial_out_o(aux), .data_ready_n_o(ready_n), .integrator_side_toggle_done_i(integrator_side_toggle_done),
    .integrator_side_toggle_words_i(integrator_side_toggle_words), .integ_cap_sel_o(cap_sel), .normal_speed_o(normal_speed),
    .reduced_12bit_o(reduced), .inputs_open_o(inputs_open), .test_cap_on_o(test_cap),
    .charge_inject_o(inject), .ref_buffer_en_o(buf_en), .cfg_word_o(cfg_word));
  host_model i_host_model (
    .clk_i(clk), .cfg_serial_o(cfg_serial), .readout_clock_o(rclk), .toggle_o(toggle),
    .chain_o(chain), .primary_i(primary));
  ////////////////////////////////////////////////////////////////////////////////
  // Word builders and comparisons
  function automatic logic [15:0] mk(input logic md, input logic [1:0] ws, input logic [1:0] rg,
    input logic sp, input logic [1:0] tm, input logic ro);
    return {1'b1, md, ws, rg, 1'b0, sp, tm, 1'b0, ro, 4'h0};
  endfunction : mk
  function automatic logic [15:0] chw(input logic [3:0] n);
    return {n, ~n, n ^ 4'h5, 4'h9};
  endfunction : chw
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // Bounded wait for the ready strobe
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_n !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      fails++;
      $display("Error at %0t: data ready timeout", $time);
      final_report();
    end
  endtask : wait_ready
  // One conversion result pulse, driven on rising edges
  task automatic pulse_integrator_side_toggle();
    @(posedge clk);
    for (int c = 0; c < 16; c++) integrator_side_toggle_words[16*c +: 16] <= chw(4'(c));
    integrator_side_toggle_done <= 1'b1;
    @(posedge clk);
    integrator_side_toggle_done <= 1'b0;
  endtask : pulse_integrator_side_toggle
  task automatic write_cfg(input logic [15:0] v);
    i_host_model.send_cfg(4'ha, v);
    i_host_model.idle_cfg();
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk_word(cfg_word, v, "config word");
  endtask : write_cfg
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk_word(cfg_word, 16'h0110, "reset word");
    chk_word({14'h0, cap_sel}, 16'h0000, "reset range");
    chk_bit(ready_n, 1'b1, "reset ready");
    chk_bit(inputs_open, 1'b0, "reset test");
  endtask : t_reset
  task automatic t_fields();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      write_cfg(mk(1'b0, 2'h0, c, c[0], c, c[1]));
      chk_word({14'h0, cap_sel}, c[1] ? 16'h3 : {15'h0, c[0]}, "range");
      chk_bit(normal_speed, c[0], "speed");
      chk_bit(reduced, ~c[0], "reduced");
      chk_bit(inputs_open, c != 2'h0, "inputs open");
      chk_bit(test_cap, c == 2'h2, "test cap");
      chk_bit(buf_en, ~c[1], "ref buffer");
    end
  endtask : t_fields
  task automatic t_preamble();
    w = cfg_word;
    i_host_model.send_cfg(4'hb, 16'h0000);
    i_host_model.idle_cfg();
    repeat (4) @(posedge clk);
    chk_word(cfg_word, w, "bad preamble");
    i_host_model.send_cfg(4'ha, mk(1'b0, 2'h1, 2'h1, 1'b1, 2'h1, 1'b1));
    write_cfg(mk(1'b0, 2'h0, 2'h2, 1'b1, 2'h0, 1'b0));
  endtask : t_preamble
  task automatic t_readback();
    w = mk(1'b1, 2'h2, 2'h1, 1'b1, 2'h2, 1'b1);
    write_cfg(w);
    wait_ready();
    for (int k = 15; k >= 0; k--) begin
      i_host_model.read_bit(b);
      chk_bit(b, w[k], "readback bit");
      if (k == 15) chk_bit(ready_n, 1'b1, "ready release");
    end
  endtask : t_readback
  task automatic t_inject();
    int seen;
    seen = 0;
    write_cfg(mk(1'b0, 2'h0, 2'h0, 1'b1, 2'h3, 1'b1));
    i_host_model.flip_toggle();
    repeat (20) @(posedge clk) seen += (inject === 1'b1);
    chk_word(16'(seen), 16'h1, "inject pulses");
  endtask : t_inject
  task automatic t_integrator_side_toggle();
    write_cfg(mk(1'b1, 2'h2, 2'h0, 1'b1, 2'h0, 1'b1));
    pulse_integrator_side_toggle();
    i_host_model.set_chain(1'b1);
    wait_ready();
    for (int k = 0; k < 196; k++) begin
      w = (k < 192) ? chw(4'(k / 12)) : 16'hffff;
      i_host_model.read_bit(b);
      chk_bit(b, w[15 - (k % 12)], "stream bit");
    end
    chk_word({13'h0, aux}, 16'h0, "aux lanes");
    i_host_model.set_chain(1'b0);
  endtask : t_integrator_side_toggle
  // Parallel mode, 14-bit words: first group on all four lanes
  task automatic t_par();
    logic [15:0] l0, l1, l2, l3;
    l0 = chw(4'h0);
    l1 = chw(4'h1);
    l2 = chw(4'h2);
    l3 = chw(4'h3);
    write_cfg(mk(1'b0, 2'h1, 2'h0, 1'b1, 2'h0, 1'b1));
    pulse_integrator_side_toggle();
    wait_ready();
    for (int k = 15; k >= 2; k--) begin
      i_host_model.read_bit(b);
      chk_bit(b, l0[k], "lane bit");
      chk_word({13'h0, aux}, {13'h0, l3[k], l2[k], l1[k]}, "aux bits");
    end
  endtask : t_par
  // Reset, then the scenario sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    integrator_side_toggle_done = 1'b0;
    integrator_side_toggle_words = '0;
    fails = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_fields();
    t_preamble();
    t_readback();
    t_inject();
    t_integrator_side_toggle();
    t_par();
    final_report();
  end
endmodule : tb
`default_nettype wire
